// ==== src/eic_pkg.sv ====
// shared constants for the e1 error insert and counter preload register page
package eic_pkg;

	// ====================
	// register offsets within the control page
	localparam logic [4:0] OFS_ERR_INS      = 5'h10;
	localparam logic [4:0] OFS_BER_PATTERN  = 5'h11;
	localparam logic [4:0] OFS_CIRC_CTRL    = 5'h12;
	localparam logic [4:0] OFS_LOAD_CTRL    = 5'h15;
	localparam logic [4:0] OFS_BER_PRE      = 5'h18;
	localparam logic [4:0] OFS_RAI_PRE      = 5'h19;
	localparam logic [4:0] OFS_FRM_PRE      = 5'h1A;
	localparam logic [4:0] OFS_BPV_PRE_HI   = 5'h1C;
	localparam logic [4:0] OFS_BPV_PRE_LO   = 5'h1D;
	localparam logic [4:0] OFS_EBIT_PRE     = 5'h1E;
	localparam logic [4:0] OFS_CRC_PRE      = 5'h1F;

	// ====================
	// field positions of the error insert and debounce word
	localparam int BIT_BPV_INS   = 7;
	localparam int BIT_CRC_INS   = 6;
	localparam int BIT_FAS_INS   = 5;
	localparam int BIT_NFAS_INS  = 4;
	localparam int BIT_LOS_INS   = 3;
	localparam int BIT_RX_BYPASS = 1;
	localparam int BIT_DEBOUNCE  = 0;

	// field positions of the circular buffer accumulate word
	localparam int BIT_B0_START_MISS = 7;
	localparam int BIT_B0_START_HIT  = 6;
	localparam int BIT_B1_START_MISS = 5;
	localparam int BIT_B1_START_HIT  = 4;
	localparam int BIT_B0_STOP_MISS  = 3;
	localparam int BIT_B0_STOP_HIT   = 2;
	localparam int BIT_B1_STOP_MISS  = 1;
	localparam int BIT_B1_STOP_HIT   = 0;

	// field positions of the counter load word
	localparam int BIT_LD_CRC  = 5;
	localparam int BIT_LD_EBIT = 4;
	localparam int BIT_LD_BPV  = 3;
	localparam int BIT_LD_FRM  = 2;
	localparam int BIT_LD_RAI  = 1;
	localparam int BIT_LD_BER  = 0;

	// ====================
	// reset values and write masks
	localparam logic [7:0] RST_ERR_INS     = 8'h00;
	localparam logic [7:0] RST_BER_PATTERN = 8'h00;
	localparam logic [7:0] RST_CIRC_CTRL   = 8'h00;
	localparam logic [7:0] RST_LOAD_CTRL   = 8'h00;
	localparam logic [7:0] MASK_ERR_INS    = 8'hFB;
	localparam logic [7:0] MASK_LOAD_CTRL  = 8'h3F;

	// expected frame alignment bits two to eight
	localparam logic [6:0] FAS_PATTERN = 7'h1B;

	// interrupt vector of start and stop buffer events
	localparam logic [7:0] IRQ_VEC_CIRC = 8'h02;

	// ====================
	// timing
	localparam int CLK_HZ         = 10_000_000;
	localparam int DEBOUNCE_MS    = 14;
	localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * (CLK_HZ / 1000);

endpackage : eic_pkg

// ==== src/eic_preload_mem.sv ====
// small storage for the seven counter preload words with registered read data
`timescale 1ns/1ps
module eic_preload_mem #(
	parameter int WORDS = 8
) (
	input  wire logic                 clk,
	input  wire logic                 wr_en,
	input  wire logic [2:0]           wr_idx,
	input  wire logic [7:0]           wr_data,
	input  wire logic [2:0]           rd_idx,
	output logic      [7:0]           rd_data,
	output logic      [WORDS*8-1:0]   all_words
);

	logic [7:0] mem [WORDS];

	// preload words carry no reset value
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem[rd_idx];
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < WORDS; i++) begin
			all_words[i*8 +: 8] <= mem[i];
		end
	end

endmodule : eic_preload_mem

// ==== src/eic_ctrl.sv ====
// error insertion, buffer trigger, debounce select and counter preload control page
// Function
// RL1 - rising bipolar violation insert bit sends one violation pulse
// RL2 - rising checksum insert bit corrupts exactly one crc-4 check
// RL3 - rising align word insert bit injects one frame alignment error
// RL4 - rising non-align insert bit corrupts bit two of one word
// RL5 - steady levels and falling edges of insert bits do nothing
// RL6 - while set, force all-zero pulseless transmit data
// RL7 - bypass disables receive framing, passes raw data, reports out of sync
// RL8 - debounce select picks 14 ms filter or none, may stretch 2 ms
// RL9 - compare pattern against buffer one data, count each mismatching bit
// RL10 - bits 7..4 arm buffer start on mismatch or match
// RL11 - bits 3..0 arm buffer stop on mismatch or match; zero disables
// RL12 - rising load bits copy load words into the matching counters
// RL13 - counter preloading acts only in serial-stream control mode
// RL14 - bit error counter preloads from byte at 18h
// RL15 - violation counter preloads high from 1ch and low from 1dh
// RL16 - remote alarm counter preloads from byte at 19h
// RL17 - frame error counter preloads from byte at 1ah
// RL18 - e-bit counter preloads from byte at 1eh
// RL19 - checksum counter preloads from byte at 1fh
// RL20 - all control bits reset to zero on reset
// RL21 - source select picks frame alignment errors or pattern mismatches
// RL22 - unmasked buffer start or stop event raises vector 00000010
// RL23 - rising edges found by comparing written value with stored value
`timescale 1ns/1ps
module eic_ctrl
	import eic_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = eic_pkg::DEBOUNCE_CYC,
	parameter int SIG_WIDTH       = 4
) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 reg_sel,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [4:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	output logic                      reg_rvalid,
	input  wire logic                 serial_mode,
	input  wire logic                 error_source_select,
	output logic                      bipolar_violation_inject,
	output logic                      checksum_error_inject,
	output logic                      align_word_error_inject,
	output logic                      nonalign_word_error_inject,
	output logic                      force_signal_absent,
	input  wire logic                 rx_line_data,
	input  wire logic                 rx_framed_data,
	input  wire logic                 framer_sync_loss,
	output logic                      serial_data_out,
	output logic                      sync_loss,
	output logic                      rx_framing_bypass,
	input  wire logic [SIG_WIDTH-1:0] rx_signalling,
	output logic                      signalling_debounce_sel,
	output logic      [SIG_WIDTH-1:0] signalling_out,
	input  wire logic                 fas_valid,
	input  wire logic [6:0]           fas_bits,
	input  wire logic                 buf_one_valid,
	input  wire logic [7:0]           buf_one_data,
	output logic                      bit_error_tally_inc,
	output logic      [3:0]           bit_error_tally_amount,
	input  wire logic                 buf_zero_code_match,
	input  wire logic                 buf_zero_code_miss,
	input  wire logic                 buf_one_code_match,
	input  wire logic                 buf_one_code_miss,
	input  wire logic                 start_irq_unmask,
	input  wire logic                 stop_irq_unmask,
	output logic                      buffer_zero_begin,
	output logic                      buffer_one_begin,
	output logic                      buffer_zero_halt,
	output logic                      buffer_one_halt,
	output logic                      circ_irq,
	output logic      [7:0]           circ_irq_vector,
	output logic                      checksum_tally_preload,
	output logic                      ebit_tally_preload,
	output logic                      violation_tally_preload,
	output logic                      frame_err_tally_preload,
	output logic                      remote_alarm_tally_preload,
	output logic                      error_rate_tally_preload,
	output logic      [7:0]           checksum_tally_value,
	output logic      [7:0]           ebit_tally_value,
	output logic      [15:0]          violation_tally_value,
	output logic      [7:0]           frame_err_tally_value,
	output logic      [7:0]           remote_alarm_tally_value,
	output logic      [7:0]           error_rate_tally_value
);

	// ====================
	// helpers

	function automatic logic [3:0] count_ones(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction : count_ones

	function automatic logic [7:0] rising(input logic [7:0] old_v, input logic [7:0] new_v);
		return new_v & ~old_v;
	endfunction : rising

	localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);

	// ====================
	// register write decode

	logic       wr_ok;
	logic       hit_err_ins;
	logic       hit_pattern;
	logic       hit_circ;
	logic       hit_load;
	logic       hit_pre;
	logic [7:0] error_insert_debounce_select;
	logic [7:0] ber_compare_pattern;
	logic [7:0] circ_buffer_accumulate_ctrl;
	logic [7:0] counter_load_strobes;
	logic [7:0] next_ins_rise;
	logic [7:0] next_load_rise;

	assign wr_ok       = reg_sel & reg_wr;
	assign hit_err_ins = wr_ok & (reg_addr == OFS_ERR_INS);
	assign hit_pattern = wr_ok & (reg_addr == OFS_BER_PATTERN);
	assign hit_circ    = wr_ok & (reg_addr == OFS_CIRC_CTRL);
	assign hit_load    = wr_ok & (reg_addr == OFS_LOAD_CTRL);
	assign hit_pre     = wr_ok & (reg_addr >= OFS_BER_PRE) & (reg_addr != 5'h1B);

	// compare the incoming byte against the stored byte so only 0->1 changes fire
	assign next_ins_rise  = hit_err_ins ? rising(error_insert_debounce_select, reg_wdata) : 8'h00; // [RL23] [RL5]
	assign next_load_rise = hit_load ? rising(counter_load_strobes, reg_wdata & MASK_LOAD_CTRL) : 8'h00; // [RL23]

	// ====================
	// control registers

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			error_insert_debounce_select <= RST_ERR_INS; // [RL20]
		end else if (hit_err_ins) begin
			error_insert_debounce_select <= reg_wdata & MASK_ERR_INS;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ber_compare_pattern <= RST_BER_PATTERN; // [RL20] [RL9]
		end else if (hit_pattern) begin
			ber_compare_pattern <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			circ_buffer_accumulate_ctrl <= RST_CIRC_CTRL; // [RL20]
		end else if (hit_circ) begin
			circ_buffer_accumulate_ctrl <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			counter_load_strobes <= RST_LOAD_CTRL; // [RL20]
		end else if (hit_load) begin
			counter_load_strobes <= reg_wdata & MASK_LOAD_CTRL;
		end
	end

	// ====================
	// preload word storage

	logic [7:0]  pre_rd_data;
	logic [63:0] pre_words;

	eic_preload_mem #(
		.WORDS(8)
	) u_pre (
		.clk      (clk),
		.wr_en    (hit_pre),
		.wr_idx   (reg_addr[2:0]),
		.wr_data  (reg_wdata),
		.rd_idx   (reg_addr[2:0]),
		.rd_data  (pre_rd_data),
		.all_words(pre_words)
	);

	// ====================
	// register read-back; reads take two cycles, the unused slot reads zero

	logic       rd_pending;
	logic [4:0] rd_addr_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_pending <= 1'b0;
			rd_addr_q  <= 5'h00;
		end else begin
			rd_pending <= reg_sel & reg_rd;
			rd_addr_q  <= reg_addr;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= rd_pending;
			if (rd_pending) begin
				unique case (rd_addr_q)
					OFS_ERR_INS:     reg_rdata <= error_insert_debounce_select;
					OFS_BER_PATTERN: reg_rdata <= ber_compare_pattern;
					OFS_CIRC_CTRL:   reg_rdata <= circ_buffer_accumulate_ctrl;
					OFS_LOAD_CTRL:   reg_rdata <= counter_load_strobes;
					OFS_BER_PRE, OFS_RAI_PRE, OFS_FRM_PRE, OFS_BPV_PRE_HI,
					OFS_BPV_PRE_LO, OFS_EBIT_PRE, OFS_CRC_PRE: reg_rdata <= pre_rd_data;
					default:         reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ====================
	// single-shot error insertion and forced signal loss

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bipolar_violation_inject   <= 1'b0;
			checksum_error_inject      <= 1'b0;
			align_word_error_inject    <= 1'b0;
			nonalign_word_error_inject <= 1'b0;
		end else begin
			// one-cycle pulse: the transmit framer acts once per pulse
			bipolar_violation_inject   <= next_ins_rise[BIT_BPV_INS];  // [RL1]
			checksum_error_inject      <= next_ins_rise[BIT_CRC_INS];  // [RL2]
			align_word_error_inject    <= next_ins_rise[BIT_FAS_INS];  // [RL3]
			nonalign_word_error_inject <= next_ins_rise[BIT_NFAS_INS]; // [RL4]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			force_signal_absent     <= 1'b0;
			rx_framing_bypass       <= 1'b0;
			signalling_debounce_sel <= 1'b0;
		end else begin
			force_signal_absent     <= error_insert_debounce_select[BIT_LOS_INS]; // [RL6]
			rx_framing_bypass       <= error_insert_debounce_select[BIT_RX_BYPASS]; // [RL7]
			signalling_debounce_sel <= error_insert_debounce_select[BIT_DEBOUNCE]; // [RL8]
		end
	end

	// ====================
	// receive framing bypass

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			serial_data_out <= 1'b0;
			sync_loss       <= 1'b1;
		end else begin
			// unframed data goes straight through; sync reports lost meanwhile
			serial_data_out <= error_insert_debounce_select[BIT_RX_BYPASS] ? rx_line_data : rx_framed_data; // [RL7]
			sync_loss       <= error_insert_debounce_select[BIT_RX_BYPASS] | framer_sync_loss; // [RL7]
		end
	end

	// ====================
	// signalling debounce: a new value must hold for the full period

	logic [SIG_WIDTH-1:0] sig_candidate;
	logic [DB_W-1:0]      db_count;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sig_candidate  <= '0;
			db_count       <= '0;
			signalling_out <= '0;
		end else if (!error_insert_debounce_select[BIT_DEBOUNCE]) begin
			sig_candidate  <= rx_signalling; // [RL8]
			db_count       <= '0;
			signalling_out <= rx_signalling;
		end else if (rx_signalling != sig_candidate) begin
			sig_candidate <= rx_signalling;
			db_count      <= '0;
		end else if (db_count == DB_W'(DEBOUNCE_CYCLES - 1)) begin
			// the multiframe alignment of the source adds up to 2 ms upstream
			signalling_out <= sig_candidate; // [RL8]
		end else begin
			db_count <= db_count + DB_W'(1);
		end
	end

	// ====================
	// bit error tally source

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_error_tally_inc    <= 1'b0;
			bit_error_tally_amount <= 4'h0;
		end else if (error_source_select) begin
			bit_error_tally_inc    <= buf_one_valid && (buf_one_data != ber_compare_pattern); // [RL21]
			bit_error_tally_amount <= buf_one_valid ? count_ones(buf_one_data ^ ber_compare_pattern) : 4'h0; // [RL9]
		end else begin
			bit_error_tally_inc    <= fas_valid && (fas_bits != FAS_PATTERN); // [RL21]
			bit_error_tally_amount <= fas_valid ? count_ones({1'b0, fas_bits ^ FAS_PATTERN}) : 4'h0;
		end
	end

	// ====================
	// circular buffer start and stop triggers

	logic next_b0_begin;
	logic next_b1_begin;
	logic next_b0_halt;
	logic next_b1_halt;

	assign next_b0_begin = (circ_buffer_accumulate_ctrl[BIT_B0_START_MISS] & buf_zero_code_miss) |
	                       (circ_buffer_accumulate_ctrl[BIT_B0_START_HIT] & buf_zero_code_match); // [RL10]
	assign next_b1_begin = (circ_buffer_accumulate_ctrl[BIT_B1_START_MISS] & buf_one_code_miss) |
	                       (circ_buffer_accumulate_ctrl[BIT_B1_START_HIT] & buf_one_code_match); // [RL10]
	assign next_b0_halt  = (circ_buffer_accumulate_ctrl[BIT_B0_STOP_MISS] & buf_zero_code_miss) |
	                       (circ_buffer_accumulate_ctrl[BIT_B0_STOP_HIT] & buf_zero_code_match); // [RL11]
	assign next_b1_halt  = (circ_buffer_accumulate_ctrl[BIT_B1_STOP_MISS] & buf_one_code_miss) |
	                       (circ_buffer_accumulate_ctrl[BIT_B1_STOP_HIT] & buf_one_code_match); // [RL11]

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			buffer_zero_begin <= 1'b0;
			buffer_one_begin  <= 1'b0;
			buffer_zero_halt  <= 1'b0;
			buffer_one_halt   <= 1'b0;
		end else begin
			buffer_zero_begin <= next_b0_begin;
			buffer_one_begin  <= next_b1_begin;
			buffer_zero_halt  <= next_b0_halt;
			buffer_one_halt   <= next_b1_halt;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			circ_irq        <= 1'b0;
			circ_irq_vector <= 8'h00;
		end else begin
			circ_irq <= (start_irq_unmask & (next_b0_begin | next_b1_begin)) |
			            (stop_irq_unmask & (next_b0_halt | next_b1_halt)); // [RL22]
			circ_irq_vector <= IRQ_VEC_CIRC; // [RL22]
		end
	end

	// ====================
	// counter preload; load words are taken one cycle after the strobe write

	logic [7:0] ld_rise_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ld_rise_q <= 8'h00;
		end else begin
			ld_rise_q <= serial_mode ? next_load_rise : 8'h00; // [RL13] [RL12]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			checksum_tally_preload     <= 1'b0;
			ebit_tally_preload         <= 1'b0;
			violation_tally_preload    <= 1'b0;
			frame_err_tally_preload    <= 1'b0;
			remote_alarm_tally_preload <= 1'b0;
			error_rate_tally_preload   <= 1'b0;
		end else begin
			checksum_tally_preload     <= ld_rise_q[BIT_LD_CRC];  // [RL12]
			ebit_tally_preload         <= ld_rise_q[BIT_LD_EBIT]; // [RL12]
			violation_tally_preload    <= ld_rise_q[BIT_LD_BPV];  // [RL12]
			frame_err_tally_preload    <= ld_rise_q[BIT_LD_FRM];  // [RL12]
			remote_alarm_tally_preload <= ld_rise_q[BIT_LD_RAI];  // [RL12]
			error_rate_tally_preload   <= ld_rise_q[BIT_LD_BER];  // [RL12]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			checksum_tally_value     <= 8'h00;
			ebit_tally_value         <= 8'h00;
			violation_tally_value    <= 16'h0000;
			frame_err_tally_value    <= 8'h00;
			remote_alarm_tally_value <= 8'h00;
			error_rate_tally_value   <= 8'h00;
		end else begin
			// values only move with their strobe, so they are stable beside it
			if (ld_rise_q[BIT_LD_BER]) begin
				error_rate_tally_value <= pre_words[OFS_BER_PRE[2:0]*8 +: 8]; // [RL14]
			end
			if (ld_rise_q[BIT_LD_BPV]) begin
				violation_tally_value <= {pre_words[OFS_BPV_PRE_HI[2:0]*8 +: 8],
				                          pre_words[OFS_BPV_PRE_LO[2:0]*8 +: 8]}; // [RL15]
			end
			if (ld_rise_q[BIT_LD_RAI]) begin
				remote_alarm_tally_value <= pre_words[OFS_RAI_PRE[2:0]*8 +: 8]; // [RL16]
			end
			if (ld_rise_q[BIT_LD_FRM]) begin
				frame_err_tally_value <= pre_words[OFS_FRM_PRE[2:0]*8 +: 8]; // [RL17]
			end
			if (ld_rise_q[BIT_LD_EBIT]) begin
				ebit_tally_value <= pre_words[OFS_EBIT_PRE[2:0]*8 +: 8]; // [RL18]
			end
			if (ld_rise_q[BIT_LD_CRC]) begin
				checksum_tally_value <= pre_words[OFS_CRC_PRE[2:0]*8 +: 8]; // [RL19]
			end
		end
	end

endmodule : eic_ctrl

// ==== verif/eic_ctrl_asserts.sv ====
// concurrent checks on the ports of the e1 control page
`timescale 1ns/1ps
module eic_ctrl_asserts (
	input wire logic        clk, rst_b, reg_sel, reg_wr, reg_rd, serial_mode, rx_line_data,
	input wire logic [4:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_rvalid, bipolar_violation_inject, force_signal_absent, rx_framing_bypass,
	input wire logic        sync_loss, serial_data_out, buf_zero_code_match, buf_zero_code_miss,
	input wire logic        buffer_zero_halt, circ_irq, checksum_tally_preload, violation_tally_preload,
	input wire logic [7:0]  circ_irq_vector,
	input wire logic [15:0] violation_tally_value
);
	// ====================
	// helpers
	logic w10, ld_crc, bz_ev;
	assign w10    = reg_sel & reg_wr & (reg_addr == 5'h10);
	assign ld_crc = reg_sel & reg_wr & (reg_addr == 5'h15) & reg_wdata[5] & serial_mode;
	assign bz_ev  = buf_zero_code_match | buf_zero_code_miss;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ====================
	// properties
	property p_bpv_once; bipolar_violation_inject |=> !bipolar_violation_inject; endproperty
	property p_bpv_cause; bipolar_violation_inject |-> $past(w10) && $past(reg_wdata[7]); endproperty
	property p_read_lat; reg_sel && reg_rd |-> ##2 reg_rvalid; endproperty
	property p_los_level; $past(w10, 2) |-> force_signal_absent == $past(reg_wdata[3], 2); endproperty
	property p_bypass; $past(rx_framing_bypass) |-> sync_loss && serial_data_out == $past(rx_line_data); endproperty
	property p_preload_gate; checksum_tally_preload |-> $past(ld_crc, 2); endproperty
	property p_value_hold; !violation_tally_preload |-> $stable(violation_tally_value); endproperty
	property p_halt_cause; buffer_zero_halt |-> $past(bz_ev); endproperty
	property p_irq_vec; circ_irq |-> circ_irq_vector == 8'h02; endproperty
	a_bpv_once: assert property (p_bpv_once) else $error("violation insert pulse too long");
	a_bpv_cause: assert property (p_bpv_cause) else $error("violation insert without write");
	a_read_lat: assert property (p_read_lat) else $error("read answer late");
	a_los_level: assert property (p_los_level) else $error("signal absent level wrong");
	a_bypass: assert property (p_bypass) else $error("bypass data or sync wrong");
	a_preload_gate: assert property (p_preload_gate) else $error("checksum preload without cause");
	a_value_hold: assert property (p_value_hold) else $error("violation value moved");
	a_halt_cause: assert property (p_halt_cause) else $error("halt without event");
	a_irq_vec: assert property (p_irq_vec) else $error("irq vector wrong");
	c_bpv: cover property (bipolar_violation_inject);
	c_pre: cover property (checksum_tally_preload);
	c_halt: cover property (buffer_zero_halt);
endmodule : eic_ctrl_asserts

bind eic_ctrl eic_ctrl_asserts u_chk (.*);

// ==== verif/e1_error_insert_counter_preload_tb.sv ====
// self-checking bench for the e1 error insert and preload page
`timescale 1ns/1ps
module e1_error_insert_counter_preload_tb;
	import eic_pkg::*;
	// ====================
	// signals
	logic clk, rst_b, reg_sel, reg_wr, reg_rd, serial_mode, error_source_select, rx_line_data, rx_framed_data;
	logic framer_sync_loss, fas_valid, buf_one_valid, buf_zero_code_match, buf_zero_code_miss;
	logic buf_one_code_match, buf_one_code_miss, start_irq_unmask, stop_irq_unmask, reg_rvalid, circ_irq;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, buf_one_data, circ_irq_vector, checksum_tally_value, ebit_tally_value;
	logic [7:0] frame_err_tally_value, remote_alarm_tally_value, error_rate_tally_value;
	logic [3:0] rx_signalling, signalling_out, bit_error_tally_amount, amt;
	logic [6:0] fas_bits;
	logic [15:0] violation_tally_value;
	logic bipolar_violation_inject, checksum_error_inject, align_word_error_inject, nonalign_word_error_inject;
	logic force_signal_absent, serial_data_out, sync_loss, rx_framing_bypass, signalling_debounce_sel;
	logic bit_error_tally_inc, buffer_zero_begin, buffer_one_begin, buffer_zero_halt, buffer_one_halt;
	logic checksum_tally_preload, ebit_tally_preload, violation_tally_preload, frame_err_tally_preload;
	logic remote_alarm_tally_preload, error_rate_tally_preload;
	logic [14:0] pv;
	int cnt[15];
	int mismatches, check_count, cyc;

	eic_ctrl #(.DEBOUNCE_CYCLES(8)) uut (.*);

	assign pv = {error_rate_tally_preload, remote_alarm_tally_preload, frame_err_tally_preload,
		violation_tally_preload, ebit_tally_preload, checksum_tally_preload, circ_irq, buffer_one_halt,
		buffer_zero_halt, buffer_one_begin, buffer_zero_begin, nonalign_word_error_inject,
		align_word_error_inject, checksum_error_inject, bipolar_violation_inject};

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ====================
	// pulse counting and hang guard
	always @(posedge clk) begin
		cyc++;
		if (bit_error_tally_inc === 1'b1) amt <= bit_error_tally_amount;
		for (int i = 0; i < 15; i++) if (pv[i] === 1'b1) cnt[i]++;
		if (cyc == 3000) begin
			mismatches++;
			print_verdict();
		end
	end

	// ====================
	// tasks
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task chkn(input int e[15]);
		for (int i = 0; i < 15; i++) chk($sformatf("pulses %0d", i), cnt[i], e[i]);
	endtask : chkn

	task wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk) {reg_sel, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
		@(negedge clk) {reg_sel, reg_wr} = 2'b00;
	endtask : wr

	// read answer waited for under a bounded count
	task rdc(input logic [4:0] a, input logic [7:0] e);
		@(negedge clk) {reg_sel, reg_rd, reg_addr} = {2'b11, a};
		@(negedge clk) {reg_sel, reg_rd} = 2'b00;
		for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clk);
		chk("read data", reg_rdata, e);
	endtask : rdc

	task ev(input logic [5:0] v);
		@(negedge clk) {fas_valid, buf_one_valid, buf_zero_code_match, buf_zero_code_miss,
			buf_one_code_match, buf_one_code_miss} = v;
		@(negedge clk) {fas_valid, buf_one_valid, buf_zero_code_match, buf_zero_code_miss,
			buf_one_code_match, buf_one_code_miss} = 6'h00;
		repeat (3) @(negedge clk);
	endtask : ev

	task print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict

	// ====================
	// main sequence
	initial begin
		{reg_sel, reg_wr, reg_rd, serial_mode, error_source_select, rx_line_data, rx_framed_data} = 7'h00;
		{framer_sync_loss, start_irq_unmask, stop_irq_unmask, reg_addr, reg_wdata, rx_signalling} = 0;
		{fas_valid, buf_one_valid, buf_zero_code_match, buf_zero_code_miss} = 4'h0;
		{buf_one_code_match, buf_one_code_miss, buf_one_data, fas_bits} = 0;
		rst_b = 1'b0;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		rdc(5'h10, 8'h00);
		rdc(5'h11, 8'h00);
		rdc(5'h12, 8'h00);
		rdc(5'h15, 8'h00);
		rdc(5'h13, 8'h00);
		$display("test reset done");
		// only rising insert bits fire, each twice over the two rising writes
		wr(5'h10, 8'hF0);
		wr(5'h10, 8'hF0);
		wr(5'h10, 8'h00);
		wr(5'h10, 8'hF0);
		wr(5'h10, 8'h0F);
		repeat (3) @(negedge clk);
		chkn('{2, 2, 2, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0});
		rdc(5'h10, 8'h0B);
		chk("signal absent", force_signal_absent, 1'b1);
		chk("debounce sel", signalling_debounce_sel, 1'b1);
		chk("bypass sync", sync_loss, 1'b1);
		rx_line_data = 1'b1;
		repeat (2) @(negedge clk);
		chk("bypass data", serial_data_out, 1'b1);
		rx_signalling = 4'h5;
		repeat (4) @(negedge clk);
		chk("debounce hold", signalling_out, 4'h0);
		repeat (8) @(negedge clk);
		chk("debounce out", signalling_out, 4'h5);
		$display("test insert done");
		// pattern compare and frame alignment bit error counts
		wr(5'h11, 8'hA5);
		rdc(5'h11, 8'hA5);
		error_source_select = 1'b1;
		buf_one_data = 8'h5A;
		ev(6'h10);
		chk("pattern errors", amt, 4'h8);
		error_source_select = 1'b0;
		fas_bits = FAS_PATTERN ^ 7'h11;
		ev(6'h20);
		chk("align errors", amt, 4'h2);
		$display("test bit error done");
		// start bits armed, then stop bits on mismatch only with the stop irq masked
		start_irq_unmask = 1'b1;
		wr(5'h12, 8'hF0);
		ev(6'h08);
		ev(6'h04);
		ev(6'h02);
		ev(6'h01);
		wr(5'h12, 8'h0A);
		ev(6'h0F);
		ev(6'h08);
		chkn('{2, 2, 2, 2, 2, 2, 1, 1, 4, 0, 0, 0, 0, 0, 0});
		$display("test buffer triggers done");
		// preload words, gating by serial mode, and only rising load bits
		serial_mode = 1'b1;
		wr(5'h18, 8'h11);
		wr(5'h19, 8'h22);
		wr(5'h1A, 8'h33);
		wr(5'h1C, 8'h44);
		wr(5'h1D, 8'h55);
		wr(5'h1E, 8'h66);
		wr(5'h1F, 8'h77);
		wr(5'h15, 8'h3F);
		repeat (3) @(negedge clk);
		chk("ber value", error_rate_tally_value, 8'h11);
		chk("rai value", remote_alarm_tally_value, 8'h22);
		chk("frame value", frame_err_tally_value, 8'h33);
		chk("bpv value", violation_tally_value, 16'h4455);
		chk("ebit value", ebit_tally_value, 8'h66);
		chk("crc value", checksum_tally_value, 8'h77);
		wr(5'h15, 8'h00);
		serial_mode = 1'b0;
		wr(5'h15, 8'h21);
		rdc(5'h15, 8'h21);
		serial_mode = 1'b1;
		wr(5'h15, 8'hFF);
		rdc(5'h15, 8'h3F);
		chkn('{2, 2, 2, 2, 2, 2, 1, 1, 4, 1, 2, 2, 2, 2, 1});
		$display("test preload done");
		print_verdict();
	end
endmodule : e1_error_insert_counter_preload_tb
